// >>> verilog/sfr_overlay_pkg.sv
// Purpose: Constants and types shared by the overlaid register bank
// Assumes: Byte-addressed Avalon-MM, one 8-bit register per aligned word
// Notes:   Storage slots are physical registers; bus indices map onto them
package sfr_overlay_pkg;

	// Geometry
	localparam int          NUM_SLOTS   = 23;      // Physical 8-bit registers
	localparam int          ADDR_W      = 6;       // Byte address width
	localparam int          SLOT_W      = 5;       // Slot number width

	// Bus-side word indices that are not plain pairs
	localparam logic [3:0]  IX_LAST_PAIR = 4'h5;   // Indices 0..5 are shared pairs
	localparam logic [3:0]  IX_SSP_ADD   = 4'h6;   // Address/baud or address mask
	localparam logic [3:0]  IX_CON2      = 4'h7;   // Port control two
	localparam logic [3:0]  IX_ADC0      = 4'h8;   // Converter ctl 0 / analog high
	localparam logic [3:0]  IX_ADC1      = 4'h9;   // Converter ctl 1 / analog low
	localparam logic [3:0]  IX_WDT       = 4'hA;   // Watchdog and map control
	localparam logic [3:0]  IX_PARH      = 4'hB;   // Parallel high storage
	localparam logic [3:0]  IX_PARL      = 4'hC;   // Parallel low storage
	localparam logic [3:0]  IX_CTL       = 4'hD;   // Local mode control

	// Physical slots
	localparam logic [4:0]  SL_OSC  = 5'h00;       // Oscillator control
	localparam logic [4:0]  SL_MEM  = 5'h0B;       // External memory control
	localparam logic [4:0]  SL_ADD  = 5'h0C;       // Port address/baud
	localparam logic [4:0]  SL_MSK  = 5'h0D;       // Port address mask
	localparam logic [4:0]  SL_CON2 = 5'h0E;       // Port control two
	localparam logic [4:0]  SL_ADC0 = 5'h0F;       // Converter control zero
	localparam logic [4:0]  SL_ANC1 = 5'h10;       // Analog pin config high
	localparam logic [4:0]  SL_ADC1 = 5'h11;       // Converter control one
	localparam logic [4:0]  SL_ANC0 = 5'h12;       // Analog pin config low
	localparam logic [4:0]  SL_WDT  = 5'h13;       // Watchdog and map control
	localparam logic [4:0]  SL_PARH = 5'h14;       // Parallel high
	localparam logic [4:0]  SL_PARL = 5'h15;       // Parallel low
	localparam logic [4:0]  SL_CTL  = 5'h16;       // Local mode control
	localparam logic [4:0]  SL_NONE = 5'h17;       // Unmapped or absent

	// Field positions and patterns
	localparam int          MAP_SEL_BIT  = 4;      // Shared-map select in watchdog reg
	localparam int          OSC_STARTUP_STATUS_BIT     = 3;      // Start-up status in oscillator reg
	localparam int          LVD_BIT      = 6;      // Low-voltage status in watchdog reg
	localparam int          PAR_MODE_BIT = 0;      // Parallel storage as data out
	localparam int          SLAVE_BIT    = 1;      // Port runs as I2C slave
	localparam logic [3:0]  MASK_PATTERN = 4'h9;   // Opens the address mask

	// Values after reset, slot 22 down to slot 0
	localparam logic [NUM_SLOTS-1:0][7:0] SLOT_RESET = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h64};

	// Writable bits, slot 22 down to slot 0
	localparam logic [NUM_SLOTS-1:0][7:0] SLOT_WMASK = {
		8'h03, 8'hFF, 8'hFF, 8'h91, 8'hDF, 8'hFF, 8'hFF, 8'hFF,
		8'hBF, 8'hFF, 8'hFF, 8'hB3, 8'hFF, 8'h01, 8'hFF, 8'h03,
		8'hBF, 8'h03, 8'hFF, 8'h1F, 8'hFF, 8'hBF, 8'hF3};

	// Bus handshake states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACK  = 2'b10
	} bus_state_t;

endpackage

// >>> verilog/shared_address_sfr_overlay.sv
// Purpose: Register bank where shared addresses reach one of two registers
// Assumes: Single core clock, synchronous active-low reset held 3+ edges
// Notes:   Peripherals behind the registers live elsewhere
`timescale 1ns/1ps

// Function
// - Select low reaches default legacy register
// - Select high reaches overlapping configuration register
// - Mask reachable only when control low nibble 1001
// - Large-package-only registers absent, read zero
// - Start-up status resets inverse of two-speed
// - Slave mode turns control bits into mask
// - Parallel address and data share storage
module shared_address_sfr_overlay #(
	parameter bit LARGE_PACKAGE = 1'b1                // 1 = larger package option
) (
	// Clock and reset
	input  wire logic                                core_clk_i,
	input  wire logic                                rst_b_i,
	// Avalon-MM slave
	input  wire logic [sfr_overlay_pkg::ADDR_W-1:0]  address_i,
	input  wire logic                                read_i,
	input  wire logic                                write_i,
	input  wire logic [31:0]                         writedata_i,
	input  wire logic [3:0]                          byteenable_i,
	output logic      [31:0]                         readdata_o,
	output logic                                     waitrequest_o,
	// Pins and status from outside this clock
	input  wire logic                                two_speed_en_i,
	input  wire logic                                lvd_status_i,
	// Block state toward the peripherals
	output logic                                     shared_map_select_o,
	output logic      [3:0]                          slave_addr_mask_o,
	output logic      [15:0]                         parallel_word_o,
	output logic                                     parallel_data_mode_o,
	output logic                                     osc_startup_status_o
);

	localparam int NS = sfr_overlay_pkg::NUM_SLOTS;

	// Slot numbers must fit the slot field, NONE included
	if (NS >= (1 << sfr_overlay_pkg::SLOT_W))
	begin : g_slot_check
		$error("Slot count does not fit slot width");
	end

	// All module state
	typedef struct packed {
		sfr_overlay_pkg::bus_state_t st;     // Handshake state
		logic                        wait_r; // Registered waitrequest
		logic [7:0]                  rdata;  // Read data held for the master
		logic [1:0]                  strap;  // Two-speed strap synchroniser
		logic [1:0]                  lvd;    // Low-voltage status synchroniser
		logic                        osc_startup_status;   // Start-up status
		logic [3:0]                  amask;  // Slave address mask out
		logic [NS-1:0][7:0]          regs;   // Physical storage
	} state_t;

	state_t q;       // Registered state
	state_t d;       // Next state
	logic [3:0] ix;  // Word index of the request
	logic sel;       // Shared-map select now
	logic [4:0] sl;  // Slot the request reaches
	logic [7:0] rv;  // Value a read returns

	// Byte address bits [1:0] are ignored; one register per word
	assign ix  = address_i[5:2];
	assign sel = q.regs[sfr_overlay_pkg::SL_WDT][sfr_overlay_pkg::MAP_SEL_BIT];

	// Word map, select low / select high:
	//   0 oscillator / reference clock out
	//   1 timer one high / open-drain one
	//   2 timer one low / open-drain two
	//   3 timer one control / open-drain three
	//   4 timer two count / pad config
	//   5 timer two period / external memory control
	//   6 address/baud, or address mask behind the pattern
	//   7 port control two, 8 converter zero / analog high
	//   9 converter one / analog low, 10 watchdog and map
	//   11 and 12 parallel storage, 13 local mode control
	// The select is read from storage, so a write that flips it
	// redirects the next access and never the one in flight
	// Bus index plus select state to physical slot
	function automatic logic [4:0] slot_of(input logic [3:0] i, input logic s,
		input logic [3:0] c2);
		logic [4:0] r;
		r = sfr_overlay_pkg::SL_NONE;
		if (i <= sfr_overlay_pkg::IX_LAST_PAIR)
		begin
			// Pairs sit side by side: default even, configuration odd
			r = {i, s};
		end
		else
		begin
			case (i)
				sfr_overlay_pkg::IX_SSP_ADD:
					// Mask only behind the pattern, select plays no part
					r = (c2 == sfr_overlay_pkg::MASK_PATTERN) ?
						sfr_overlay_pkg::SL_MSK : sfr_overlay_pkg::SL_ADD;
				sfr_overlay_pkg::IX_CON2: r = sfr_overlay_pkg::SL_CON2;
				sfr_overlay_pkg::IX_ADC0:
					r = s ? sfr_overlay_pkg::SL_ANC1 : sfr_overlay_pkg::SL_ADC0;
				sfr_overlay_pkg::IX_ADC1:
					r = s ? sfr_overlay_pkg::SL_ANC0 : sfr_overlay_pkg::SL_ADC1;
				sfr_overlay_pkg::IX_WDT:  r = sfr_overlay_pkg::SL_WDT;
				sfr_overlay_pkg::IX_PARH: r = sfr_overlay_pkg::SL_PARH;
				sfr_overlay_pkg::IX_PARL: r = sfr_overlay_pkg::SL_PARL;
				sfr_overlay_pkg::IX_CTL:  r = sfr_overlay_pkg::SL_CTL;
				default:                  r = sfr_overlay_pkg::SL_NONE;
			endcase
		end
		// Absent on the small package: reads zero, writes dropped
		if (r == sfr_overlay_pkg::SL_MEM && !LARGE_PACKAGE)
		begin
			r = sfr_overlay_pkg::SL_NONE;
		end
		return r;
	endfunction

	assign sl = slot_of(ix, sel, q.regs[sfr_overlay_pkg::SL_CON2][3:0]);

	// Read value with status bits merged in
	always_comb
	begin
		rv = 8'h00;
		// Out-of-range slots read zero rather than unknown
		if (sl < sfr_overlay_pkg::SL_NONE)
		begin
			rv = q.regs[sl];
		end
		if (sl == sfr_overlay_pkg::SL_OSC)
		begin
			// Bit 2 reads one, start-up status is read-only
			rv = {q.regs[sl][7:4], q.osc_startup_status, 1'b1, q.regs[sl][1:0]};
		end
		if (sl == sfr_overlay_pkg::SL_WDT)
		begin
			rv[sfr_overlay_pkg::LVD_BIT] = q.lvd[1];
		end
	end

	// Next-state logic
	// Reset is applied last so it overrides any access in flight; the
	// synchronisers stay out of it on purpose, so the strap is already
	// settled when the start-up status takes its value
	always_comb
	begin
		d = q;
		// Synchronisers run through reset so the strap is settled at release
		d.strap = {q.strap[0], two_speed_en_i};
		d.lvd   = {q.lvd[0], lvd_status_i};
		case (q.st)
			sfr_overlay_pkg::ST_IDLE:
			begin
				// One wait state: answer on the following cycle
				if (read_i || write_i)
				begin
					d.st     = sfr_overlay_pkg::ST_ACK;
					d.wait_r = 1'b0;
					d.rdata  = read_i ? rv : 8'h00;
				end
			end
			sfr_overlay_pkg::ST_ACK:
			begin
				d.st     = sfr_overlay_pkg::ST_IDLE;
				d.wait_r = 1'b1;
				// Write lands on the edge that sees waitrequest low
				if (write_i && byteenable_i[0] && sl < sfr_overlay_pkg::SL_NONE)
				begin
					// Only the selected slot of a pair is touched
					d.regs[sl] = (q.regs[sl] & ~sfr_overlay_pkg::SLOT_WMASK[sl]) |
						(writedata_i[7:0] & sfr_overlay_pkg::SLOT_WMASK[sl]);
				end
			end
			default:
			begin
				d.st     = sfr_overlay_pkg::ST_IDLE;
				d.wait_r = 1'b1;
			end
		endcase
		// Slave mode lends bits 5..2 to address masking
		if (d.regs[sfr_overlay_pkg::SL_CTL][sfr_overlay_pkg::SLAVE_BIT])
		begin
			d.amask = d.regs[sfr_overlay_pkg::SL_CON2][5:2];
		end
		else
		begin
			d.amask = 4'h0;
		end
		if (!rst_b_i)
		begin
			d.st     = sfr_overlay_pkg::ST_IDLE;
			d.wait_r = 1'b1;
			d.rdata  = 8'h00;
			d.amask  = 4'h0;
			d.regs   = sfr_overlay_pkg::SLOT_RESET;
			// Clear when two-speed start-up is on, set when off
			d.osc_startup_status   = ~q.strap[1];
		end
	end

	// State register
	always_ff @(posedge core_clk_i)
	begin
		q <= d;
	end

	// Outputs straight from flops
	assign readdata_o           = {24'h00_0000, q.rdata};
	assign waitrequest_o        = q.wait_r;
	assign shared_map_select_o  = sel;
	assign slave_addr_mask_o    = q.amask;
	// Same storage serves as address or data, mode bit says which
	assign parallel_word_o      = {q.regs[sfr_overlay_pkg::SL_PARH],
		q.regs[sfr_overlay_pkg::SL_PARL]};
	assign parallel_data_mode_o = q.regs[sfr_overlay_pkg::SL_CTL][sfr_overlay_pkg::PAR_MODE_BIT];
	assign osc_startup_status_o = q.osc_startup_status;

	// Checks
	// They watch the outputs and the storage against the bus inputs and
	// the strap; reads are judged one edge after the idle edge, when the
	// held read data stands for the master
	logic idle_req;  // Request seen while idle
	logic ack_wr;    // Write completing now
	assign idle_req = (q.st == sfr_overlay_pkg::ST_IDLE) && (read_i || write_i);
	assign ack_wr   = (q.st == sfr_overlay_pkg::ST_ACK) && write_i && byteenable_i[0];

	sequence s_answer;
		!waitrequest_o ##1 waitrequest_o;
	endsequence

	property p_one_wait;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		idle_req |=> s_answer;
	endproperty
	bus_answer_a: assert property (p_one_wait) else $error("Answer not one wait state");

	default_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(idle_req && read_i && ix == 4'h0 && !sel) |=>
		readdata_o[7:4] == q.regs[sfr_overlay_pkg::SL_OSC][7:4])
		else $error("Default register not read with select low");

	config_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(idle_req && read_i && ix == 4'h1 && sel) |=> readdata_o[7:0] == q.regs[3])
		else $error("Config register not read with select high");

	mask_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(idle_req && ix == sfr_overlay_pkg::IX_SSP_ADD) |->
		(sl == sfr_overlay_pkg::SL_MSK) == (q.regs[sfr_overlay_pkg::SL_CON2][3:0] == 4'h9))
		else $error("Address mask gate wrong");

	small_pkg_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(idle_req && read_i && ix == 4'h5 && sel && !LARGE_PACKAGE) |=>
		readdata_o == 32'h0000_0000)
		else $error("Absent register read nonzero");

	// First edge that sees reset released
	sequence s_reset_release;
		!rst_b_i ##1 rst_b_i;
	endsequence

	// At release the start-up status is the inverse of the strap
	startup_bit_a: assert property (@(posedge core_clk_i)
		s_reset_release |-> osc_startup_status_o == !two_speed_en_i)
		else $error("Start-up status reset value wrong");

	// Outside reset the start-up status never moves
	startup_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		$past(rst_b_i) |-> $stable(osc_startup_status_o))
		else $error("Start-up status changed outside reset");

	slave_mask_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		$past(rst_b_i) |-> slave_addr_mask_o == (q.regs[sfr_overlay_pkg::SL_CTL][1] ?
		q.regs[sfr_overlay_pkg::SL_CON2][5:2] : 4'h0))
		else $error("Slave address mask wrong");

	par_store_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ack_wr && ix == sfr_overlay_pkg::IX_PARH) |=>
		parallel_word_o[15:8] == $past(writedata_i[7:0]))
		else $error("Parallel storage not written");

	pair_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ack_wr && ix == 4'h2 && sel) |=> $stable(q.regs[4]))
		else $error("Unselected register changed");

	// Converter pair follows the same select as the plain pairs
	adc_default_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(idle_req && read_i && ix == sfr_overlay_pkg::IX_ADC0 && !sel) |=>
		readdata_o[7:0] == q.regs[sfr_overlay_pkg::SL_ADC0])
		else $error("Converter default not read with select low");

	analog_config_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(idle_req && read_i && ix == sfr_overlay_pkg::IX_ADC1 && sel) |=>
		readdata_o[7:0] == q.regs[sfr_overlay_pkg::SL_ANC0])
		else $error("Analog config not read with select high");

	// With the pattern closed the shared word reads address/baud
	addr_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(idle_req && read_i && ix == sfr_overlay_pkg::IX_SSP_ADD &&
		q.regs[sfr_overlay_pkg::SL_CON2][3:0] != sfr_overlay_pkg::MASK_PATTERN) |=>
		readdata_o[7:0] == q.regs[sfr_overlay_pkg::SL_ADD])
		else $error("Address register not read with pattern closed");

	// A write behind the pattern must leave the address/baud register alone
	mask_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ack_wr && ix == sfr_overlay_pkg::IX_SSP_ADD &&
		q.regs[sfr_overlay_pkg::SL_CON2][3:0] == sfr_overlay_pkg::MASK_PATTERN) |=>
		$stable(q.regs[sfr_overlay_pkg::SL_ADD]))
		else $error("Address register changed by a mask write");

	// Small package drops writes to the absent memory control register
	small_drop_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ack_wr && ix == 4'h5 && sel && !LARGE_PACKAGE) |=>
		$stable(q.regs[sfr_overlay_pkg::SL_MEM]))
		else $error("Absent register took a write");

	// A configuration-side write spares the hidden converter register
	adc_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ack_wr && ix == sfr_overlay_pkg::IX_ADC0 && sel) |=>
		$stable(q.regs[sfr_overlay_pkg::SL_ADC0]))
		else $error("Hidden converter register changed");

	// In slave mode a control-two write shows on the mask one edge later
	sequence s_slave_con2_write;
		ack_wr && ix == sfr_overlay_pkg::IX_CON2 &&
		q.regs[sfr_overlay_pkg::SL_CTL][sfr_overlay_pkg::SLAVE_BIT];
	endsequence

	slave_follow_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		s_slave_con2_write |=> slave_addr_mask_o == $past(writedata_i[5:2]))
		else $error("Slave mask did not follow control two");

	// Mode bit tags the shared parallel storage as address or data
	par_mode_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ack_wr && ix == sfr_overlay_pkg::IX_CTL) |=>
		parallel_data_mode_o == $past(writedata_i[0]))
		else $error("Parallel mode bit not written");

	par_low_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ack_wr && ix == sfr_overlay_pkg::IX_PARL) |=>
		parallel_word_o[7:0] == $past(writedata_i[7:0]))
		else $error("Parallel low storage not written");

endmodule // shared_address_sfr_overlay

// >>> verif/shared_address_sfr_overlay_tb.sv
// Purpose: Self-checking bench for the overlaid register bank
// Assumes: Master holds each request until waitrequest is sampled low
// Notes:   A small-package twin shares the bus and is read alongside
`timescale 1ns/1ps

module shared_address_sfr_overlay_tb;

	logic        clk      = 1'b0;     // Core clock, 200 MHz
	logic        rst_b    = 1'b0;     // Synchronous reset, low active
	logic [5:0]  addr     = 6'h00;    // Byte address
	logic        rd_en    = 1'b0;     // Avalon read
	logic        wr_en    = 1'b0;     // Avalon write
	logic [31:0] wdata    = 32'h0000_0000;
	logic        two_spd  = 1'b1;     // Two-speed start-up strap
	logic        lvd      = 1'b1;     // Low-voltage status
	logic [31:0] rdata;               // Large package read data
	logic [31:0] rdata_sm;            // Small package read data
	logic        wait_req;            // Large package waitrequest
	logic        sel;
	logic [3:0]  amask;
	logic [15:0] pword;
	logic        pmode;
	logic        osc_startup_status;
	logic [31:0] got;                 // Data taken at the answer edge
	logic [31:0] got_sm;
	int          num_errors = 0;
	int          compares   = 0;
	int          cycles     = 0;
	// Config-side writable masks, indices 1..5
	logic [7:0]  cfg_mask [1:5] = '{8'h1F, 8'h03, 8'h03, 8'h01, 8'hB3};

	// Free-running clock
	always #2.5 clk = ~clk;

	shared_address_sfr_overlay #(.LARGE_PACKAGE(1'b1)) dut_u (
		.core_clk_i(clk), .rst_b_i(rst_b), .address_i(addr), .read_i(rd_en),
		.write_i(wr_en), .writedata_i(wdata), .byteenable_i(4'h1),
		.readdata_o(rdata), .waitrequest_o(wait_req), .two_speed_en_i(two_spd),
		.lvd_status_i(lvd), .shared_map_select_o(sel), .slave_addr_mask_o(amask),
		.parallel_word_o(pword), .parallel_data_mode_o(pmode),
		.osc_startup_status_o(osc_startup_status));

	// Same bus, smaller package; answers in lock step
	shared_address_sfr_overlay #(.LARGE_PACKAGE(1'b0)) dut_small_u (
		.core_clk_i(clk), .rst_b_i(rst_b), .address_i(addr), .read_i(rd_en),
		.write_i(wr_en), .writedata_i(wdata), .byteenable_i(4'h1),
		.readdata_o(rdata_sm), .waitrequest_o(), .two_speed_en_i(two_spd),
		.lvd_status_i(lvd), .shared_map_select_o(), .slave_addr_mask_o(),
		.parallel_word_o(), .parallel_data_mode_o(), .osc_startup_status_o());

	// Closing report, the only exit
	task automatic wrap_up();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard; the whole run needs well under 2000 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// One Avalon access; held until waitrequest is sampled low
	task automatic acc(input logic wr, input logic [3:0] ix, input logic [7:0] wd);
		@(posedge clk);
		addr  <= {ix, 2'b00};
		rd_en <= ~wr;
		wr_en <= wr;
		wdata <= {24'h00_0000, wd};
		do
			@(posedge clk);
		while (wait_req !== 1'b0);
		got    = rdata;
		got_sm = rdata_sm;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] ix, input logic [7:0] wd);
		acc(1'b1, ix, wd);
	endtask

	task automatic rd(input logic [3:0] ix, input logic [7:0] e);
		acc(1'b0, ix, 8'h00);
		chk(got, {24'h00_0000, e});
	endtask

	// Reset held for 16 cycles, then one settling edge
	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
	endtask

	initial
	begin
		do_reset();
		// Start-up status follows the strap inversely
		chk({31'h0, osc_startup_status}, 32'h0000_0000);
		rd(4'h0, 8'h64);
		rd(4'h5, 8'hFF);
		// Legacy side written first
		for (int i = 1; i <= 5; i++)
			wr(i[3:0], 8'hA5);
		wr(4'hA, 8'h10);
		@(posedge clk);
		chk({31'h0, sel}, 32'h0000_0001);
		rd(4'hA, 8'h50);
		rd(4'h5, 8'h00);
		chk(got_sm, 32'h0000_0000);
		for (int i = 1; i <= 5; i++)
			wr(i[3:0], 8'hFF);
		for (int i = 1; i <= 5; i++)
			rd(i[3:0], cfg_mask[i]);
		chk(got_sm, 32'h0000_0000);
		// Converter pair on its configuration side
		wr(4'h8, 8'h3C);
		wr(4'h9, 8'hFF);
		rd(4'h9, 8'hDF);
		// Back to legacy: values untouched by config writes
		wr(4'hA, 8'h00);
		@(posedge clk);
		chk({31'h0, sel}, 32'h0000_0000);
		for (int i = 1; i <= 5; i++)
			rd(i[3:0], 8'hA5);
		chk(got_sm, 32'h0000_00A5);
		rd(4'h8, 8'h00);
		wr(4'h8, 8'h81);
		rd(4'h8, 8'h81);
		// Low-voltage status reaches bit 6 through two flops
		lvd <= 1'b0;
		repeat (3) @(posedge clk);
		rd(4'hA, 8'h00);
		// Address mask opens only on pattern 1001
		wr(4'h6, 8'h33);
		wr(4'h7, 8'h29);
		wr(4'h6, 8'h5A);
		rd(4'h6, 8'h5A);
		wr(4'h7, 8'h28);
		rd(4'h6, 8'h33);
		// Slave mode turns control bits 5..2 into mask bits
		chk({28'h0, amask}, 32'h0000_0000);
		wr(4'hD, 8'h02);
		@(posedge clk);
		chk({28'h0, amask}, 32'h0000_000A);
		wr(4'h7, 8'h14);
		@(posedge clk);
		chk({28'h0, amask}, 32'h0000_0005);
		wr(4'hD, 8'h00);
		@(posedge clk);
		chk({28'h0, amask}, 32'h0000_0000);
		// Parallel storage serves both meanings
		wr(4'hB, 8'hAB);
		wr(4'hC, 8'hCD);
		@(posedge clk);
		chk({16'h0, pword}, 32'h0000_ABCD);
		wr(4'hD, 8'h01);
		@(posedge clk);
		chk({31'h0, pmode}, 32'h0000_0001);
		rd(4'hB, 8'hAB);
		// Unmapped word reads zero
		rd(4'hE, 8'h00);
		// Second reset with two-speed disabled
		two_spd <= 1'b0;
		do_reset();
		chk({31'h0, osc_startup_status}, 32'h0000_0001);
		rd(4'h0, 8'h6C);
		wrap_up();
	end

endmodule // shared_address_sfr_overlay_tb
